// >>> design/dmd_divider.sv
`timescale 1ns/100ps
// Function
// - Prescaler divides oscillator edges by 50 or 51, one pulse per count.
// - Locked divider output runs at 1 kHz, compared with 1 kHz reference.
// - Swallow count at zero forces modulus high, divide-by-50 for cycle rest.
// - Prescaler pulse at main count one reloads both counters and pulses the divider output.
// - Two register sets kept: transmit carrier and receive beat oscillator.
// - Key low selects carrier set; key high selects beat oscillator set.
// - Output disable bit high turns the oscillator output off.
// - Self-test disable bit high disables the self-test detector.
// - Phase outputs idle high, pulse low for the phase error duration.
// - Main preload is 111, 00, then five programmable bits: 896 to 927.
// - Swallow preload is a full 6-bit value, 0 through 63.
// - Counters preload on the edge that raises the divider pulse, before the next oscillator edge.
// - Every prescaler pulse except the reloading one decrements the main counter by one.
// - Nonzero swallow starts at divide-by-51; zero starts at divide-by-50.
// - Swallow zero gives one output per 50 times main preload edges.
// - Fixed divide-by-100 stage makes the final oscillator output.
// - Register contents reach counter preloads as parallel binary.
module dmd_divider (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic vco_i,
  input wire logic ref_i,
  input wire logic transmit_keying_input_i,
  input wire logic module_control_bus_clk_i,
  input wire logic module_control_bus_data_i,
  input wire logic [3:0] module_control_bus_strobe_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  output logic modulus_high_o,
  output logic div_pulse_o,
  output logic phase_r_o,
  output logic phase_v_o,
  output logic lo_out_o,
  output logic lo_output_disable_bit_o,
  output logic selftest_disable_bit_o
);

  localparam int SYNC_W = 9;

  logic [SYNC_W-1:0] sync_level;
  logic [SYNC_W-1:0] sync_rise;
  logic vco_rise;
  logic ref_rise;
  logic key_level;
  logic ser_clk_rise;
  logic ser_data;
  logic [3:0] strobe_rise;

  logic [7:0] shifter;
  logic [7:0] car_low;
  logic [dmd_pkg::MAIN_PROG_W-1:0] car_main;
  logic [7:0] beat_low;
  logic [dmd_pkg::MAIN_PROG_W-1:0] beat_main;

  logic run_enable;
  logic beat_active;
  logic [dmd_pkg::SWALLOW_W-1:0] swallow_cnt;
  logic [dmd_pkg::MAIN_W-1:0] main_cnt;
  logic [5:0] presc_cnt;
  logic [5:0] presc_mod;
  logic presc_pulse;
  logic reload;
  logic [7:0] next_low;
  logic [dmd_pkg::MAIN_PROG_W-1:0] next_main_prog;

  logic [6:0] out_div_cnt;
  logic out_toggle;
  dmd_pkg::dmd_pd_type pd_state;

  logic wb_req;
  logic wb_commit;
  logic [31:0] rd_data;

  // Fixed upper bits of the main preload
  function automatic logic [dmd_pkg::MAIN_W-1:0] main_preload(
    input logic [dmd_pkg::MAIN_PROG_W-1:0] prog
  );
    main_preload = {dmd_pkg::MAIN_FIXED_HIGH, dmd_pkg::MAIN_FIXED_MID, prog};
  endfunction

  function automatic logic [dmd_pkg::SWALLOW_W-1:0] swallow_preload(
    input logic [7:0] low
  );
    swallow_preload = low[dmd_pkg::SWALLOW_W-1:0];
  endfunction

  dmd_sync #(
    .WIDTH(SYNC_W)
  ) u_sync (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .async_i({transmit_keying_input_i, module_control_bus_strobe_i,
              module_control_bus_data_i, module_control_bus_clk_i, ref_i, vco_i}),
    .level_o(sync_level),
    .rise_o(sync_rise),
    .fall_o()
  );

  assign vco_rise = sync_rise[0];
  assign ref_rise = sync_rise[1];
  assign ser_clk_rise = sync_rise[2];
  assign ser_data = sync_level[3];
  assign strobe_rise = sync_rise[7:4];
  assign key_level = sync_level[8];

  // Shared serial shifter, data and clock share one sync delay
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      shifter <= dmd_pkg::SHIFT_RESET;
    end else if (ser_clk_rise) begin
      shifter <= {shifter[6:0], ser_data};
    end
  end

  // Strobes latch the shifter into one of four registers
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      car_low <= dmd_pkg::LOW_RESET;
      car_main <= dmd_pkg::MAIN_PROG_RESET;
      beat_low <= dmd_pkg::LOW_RESET;
      beat_main <= dmd_pkg::MAIN_PROG_RESET;
    end else begin
      if (strobe_rise[dmd_pkg::STB_CAR_LOW]) begin
        car_low <= shifter;
      end
      if (strobe_rise[dmd_pkg::STB_CAR_MAIN]) begin
        car_main <= shifter[dmd_pkg::MAIN_PROG_W-1:0];
      end
      if (strobe_rise[dmd_pkg::STB_BEAT_LOW]) begin
        beat_low <= shifter;
      end
      if (strobe_rise[dmd_pkg::STB_BEAT_MAIN]) begin
        beat_main <= shifter[dmd_pkg::MAIN_PROG_W-1:0];
      end
    end
  end

  // Set chosen by the live key, sampled at reload and on every cycle while the divider is stopped
  always_comb begin
    if (key_level) begin
      next_low = beat_low;
      next_main_prog = beat_main;
    end else begin
      next_low = car_low;
      next_main_prog = car_main;
    end
  end

  // Modulus follows the swallow count
  assign modulus_high_o = (swallow_cnt == '0);
  assign presc_mod = modulus_high_o ? dmd_pkg::PRESC_MOD_LOW : dmd_pkg::PRESC_MOD_HIGH;
  assign presc_pulse = run_enable && vco_rise && (presc_cnt == presc_mod - 6'h01);
  assign reload = presc_pulse && (main_cnt == {{(dmd_pkg::MAIN_W-1){1'b0}}, 1'b1});

  // Count restarts at each boundary, so a modulus change never splits a count
  always_ff @(posedge clk_i) begin
    if (rst_i || !run_enable) begin
      presc_cnt <= '0;
    end else if (presc_pulse) begin
      presc_cnt <= '0;
    end else if (vco_rise) begin
      presc_cnt <= presc_cnt + 6'h01;
    end
  end

  // Reload lands in the pulse cycle, well ahead of the next VCO edge
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      main_cnt <= main_preload(dmd_pkg::MAIN_PROG_RESET);
      swallow_cnt <= swallow_preload(dmd_pkg::LOW_RESET);
      beat_active <= 1'b0;
    end else if (!run_enable || reload) begin
      main_cnt <= main_preload(next_main_prog);
      swallow_cnt <= swallow_preload(next_low);
      beat_active <= key_level;
    end else if (presc_pulse) begin
      main_cnt <= main_cnt - {{(dmd_pkg::MAIN_W-1){1'b0}}, 1'b1};
      if (swallow_cnt != '0) begin
        swallow_cnt <= swallow_cnt - {{(dmd_pkg::SWALLOW_W-1){1'b0}}, 1'b1};
      end
    end
  end

  // Divider output, one clock wide, nominally at the reference rate
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      div_pulse_o <= 1'b0;
    end else begin
      div_pulse_o <= reload;
    end
  end

  // Control bits follow the set in use since the last reload
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      lo_output_disable_bit_o <= dmd_pkg::LOW_RESET[dmd_pkg::LOW_OUT_DIS_BIT];
      selftest_disable_bit_o <= dmd_pkg::LOW_RESET[dmd_pkg::LOW_TEST_DIS_BIT];
    end else if (beat_active) begin
      lo_output_disable_bit_o <= beat_low[dmd_pkg::LOW_OUT_DIS_BIT];
      selftest_disable_bit_o <= beat_low[dmd_pkg::LOW_TEST_DIS_BIT];
    end else begin
      lo_output_disable_bit_o <= car_low[dmd_pkg::LOW_OUT_DIS_BIT];
      selftest_disable_bit_o <= car_low[dmd_pkg::LOW_TEST_DIS_BIT];
    end
  end

  // Fixed divide-by-100 free runs on every VCO edge
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      out_div_cnt <= '0;
      out_toggle <= 1'b0;
    end else if (vco_rise) begin
      if (out_div_cnt == dmd_pkg::OUT_DIV_HALF - 7'h01) begin
        out_div_cnt <= '0;
        out_toggle <= ~out_toggle;
      end else begin
        out_div_cnt <= out_div_cnt + 7'h01;
      end
    end
  end

  // Registered so the pin cannot glitch while the disable bit moves
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      lo_out_o <= 1'b0;
    end else begin
      lo_out_o <= out_toggle & ~lo_output_disable_bit_o;
    end
  end

  // Phase-frequency detector; coincident edges cancel to idle
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pd_state <= dmd_pkg::DMD_PD_IDLE;
    end else begin
      case (pd_state)
        dmd_pkg::DMD_PD_IDLE: begin
          if (ref_rise && !reload) begin
            pd_state <= dmd_pkg::DMD_PD_UP;
          end else if (reload && !ref_rise) begin
            pd_state <= dmd_pkg::DMD_PD_DOWN;
          end
        end
        dmd_pkg::DMD_PD_UP: begin
          if (reload) begin
            pd_state <= dmd_pkg::DMD_PD_IDLE;
          end
        end
        dmd_pkg::DMD_PD_DOWN: begin
          if (ref_rise) begin
            pd_state <= dmd_pkg::DMD_PD_IDLE;
          end
        end
        default: begin
          pd_state <= dmd_pkg::DMD_PD_IDLE;
        end
      endcase
    end
  end

  assign phase_r_o = (pd_state != dmd_pkg::DMD_PD_UP);
  assign phase_v_o = (pd_state != dmd_pkg::DMD_PD_DOWN);

  // Classic Wishbone slave, one wait state, ack drops after one cycle
  assign wb_req = wb_cyc_i && wb_stb_i && !wb_ack_o;

  // Writes land on the ack edge, where the master completes the cycle
  assign wb_commit = wb_cyc_i && wb_stb_i && wb_ack_o;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
    end else begin
      wb_ack_o <= wb_req;
    end
  end

  // Stopping the divider parks the counters on their preloads
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      run_enable <= dmd_pkg::CTRL_RESET[0];
    end else if (wb_commit && wb_we_i && wb_sel_i[0] &&
                 wb_adr_i == dmd_pkg::ADR_CTRL) begin
      run_enable <= wb_dat_i[0];
    end
  end

  always_comb begin
    rd_data = 32'h0000_0000;
    case (wb_adr_i)
      dmd_pkg::ADR_CTRL: begin
        rd_data = {31'h0000_0000, run_enable};
      end
      dmd_pkg::ADR_STATUS: begin
        rd_data = {26'h000_0000, selftest_disable_bit_o, lo_output_disable_bit_o,
                   (pd_state == dmd_pkg::DMD_PD_IDLE), key_level, modulus_high_o,
                   beat_active};
      end
      dmd_pkg::ADR_COUNT: begin
        rd_data = {10'h000, swallow_cnt, 6'h00, main_cnt};
      end
      dmd_pkg::ADR_CAR_LOW: begin
        rd_data = {24'h00_0000, car_low};
      end
      dmd_pkg::ADR_CAR_MAIN: begin
        rd_data = {27'h000_0000, car_main};
      end
      dmd_pkg::ADR_BEAT_LOW: begin
        rd_data = {24'h00_0000, beat_low};
      end
      dmd_pkg::ADR_BEAT_MAIN: begin
        rd_data = {27'h000_0000, beat_main};
      end
      default: begin
        rd_data = 32'h0000_0000;
      end
    endcase
  end

  // Captured with the request; stands until the next request
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_dat_o <= 32'h0000_0000;
    end else if (wb_req) begin
      wb_dat_o <= wb_we_i ? 32'h0000_0000 : rd_data;
    end
  end

endmodule

// >>> design/dmd_pkg.sv
package dmd_pkg;

  // Clock and nominal loop frequencies
  localparam int CLK_FREQ_HZ = 125000000;
  localparam int REF_FREQ_HZ = 1000;
  localparam int VCO_NOMINAL_HZ = 45500000;

  // Prescaler moduli and fixed output divider
  localparam logic [5:0] PRESC_MOD_LOW = 6'h32;
  localparam logic [5:0] PRESC_MOD_HIGH = 6'h33;
  localparam logic [6:0] OUT_DIV_HALF = 7'h32;

  // Counter widths and preload field layout
  localparam int MAIN_W = 10;
  localparam int SWALLOW_W = 6;
  localparam int MAIN_PROG_W = 5;
  localparam logic [2:0] MAIN_FIXED_HIGH = 3'h7;
  localparam logic [1:0] MAIN_FIXED_MID = 2'h0;
  localparam int LOW_OUT_DIS_BIT = 6;
  localparam int LOW_TEST_DIS_BIT = 7;

  // Serial register strobe indices
  localparam int STB_CAR_LOW = 0;
  localparam int STB_CAR_MAIN = 1;
  localparam int STB_BEAT_LOW = 2;
  localparam int STB_BEAT_MAIN = 3;

  // Wishbone byte offsets
  localparam logic [7:0] ADR_CTRL = 8'h00;
  localparam logic [7:0] ADR_STATUS = 8'h04;
  localparam logic [7:0] ADR_COUNT = 8'h08;
  localparam logic [7:0] ADR_CAR_LOW = 8'h0c;
  localparam logic [7:0] ADR_CAR_MAIN = 8'h10;
  localparam logic [7:0] ADR_BEAT_LOW = 8'h14;
  localparam logic [7:0] ADR_BEAT_MAIN = 8'h18;

  // Reset values: 455.00 kHz, swallow 0, main 910
  localparam logic [7:0] LOW_RESET = 8'h00;
  localparam logic [4:0] MAIN_PROG_RESET = 5'h0e;
  localparam logic [7:0] SHIFT_RESET = 8'h00;
  localparam logic [0:0] CTRL_RESET = 1'h1;

  typedef enum logic [2:0] {
    DMD_PD_IDLE = 3'b001,
    DMD_PD_UP = 3'b010,
    DMD_PD_DOWN = 3'b100
  } dmd_pd_type;

endpackage

// >>> design/dmd_sync.sv
`timescale 1ns/100ps
module dmd_sync #(
  parameter int WIDTH = 1
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [WIDTH-1:0] async_i,
  output logic [WIDTH-1:0] level_o,
  output logic [WIDTH-1:0] rise_o,
  output logic [WIDTH-1:0] fall_o
);

  logic [WIDTH-1:0] stage1;
  logic [WIDTH-1:0] stage2;
  logic [WIDTH-1:0] stage3;

  // Stage1 feeds only stage2 to keep metastability contained
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      stage1 <= '0;
      stage2 <= '0;
      stage3 <= '0;
    end else begin
      stage1 <= async_i;
      stage2 <= stage1;
      stage3 <= stage2;
    end
  end

  assign level_o = stage2;
  assign rise_o = stage2 & ~stage3;
  assign fall_o = ~stage2 & stage3;

endmodule

// >>> sim/dmd_ctrl_model.sv
`timescale 1ns/100ps
module dmd_ctrl_model (
  input wire logic clk_i,
  output logic ser_clk_o,
  output logic ser_data_o,
  output logic [3:0] strobe_o
);
  initial begin
    ser_clk_o = 1'b0;
    ser_data_o = 1'b0;
    strobe_o = 4'h0;
  end
  task automatic gap();
    repeat (4) @(posedge clk_i);
  endtask
  // Clock idles low between frames; data inverted once its hold is over
  task automatic send(input int idx, input logic [7:0] val);
    for (int i = 7; i >= 0; i--) begin
      ser_data_o <= val[i];
      gap();
      ser_clk_o <= 1'b1;
      gap();
      ser_clk_o <= 1'b0;
    end
    gap();
    strobe_o[idx] <= 1'b1;
    gap();
    strobe_o[idx] <= 1'b0;
    ser_data_o <= ~val[0];
    gap();
  endtask
endmodule

// >>> sim/dmd_divider_sva.sv
`timescale 1ns/100ps
module dmd_divider_chk (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ref_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  input wire logic modulus_high_o,
  input wire logic div_pulse_o,
  input wire logic phase_r_o,
  input wire logic phase_v_o,
  input wire logic lo_out_o,
  input wire logic lo_output_disable_bit_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  property p_idle_reset;
    $fell(rst_i) |-> phase_r_o && phase_v_o && modulus_high_o && !div_pulse_o;
  endproperty
  a_idle_reset: assert property (p_idle_reset)
    else $error("outputs not idle after reset");
  property p_pfd_excl;
    !(!phase_r_o && !phase_v_o);
  endproperty
  a_pfd_excl: assert property (p_pfd_excl)
    else $error("both phase outputs low");
  property p_ref_cause;
    $fell(phase_r_o) |-> $past(ref_i, 2);
  endproperty
  a_ref_cause: assert property (p_ref_cause)
    else $error("phase_r fell without reference");
  property p_v_cause;
    $fell(phase_v_o) |-> div_pulse_o;
  endproperty
  a_v_cause: assert property (p_v_cause)
    else $error("phase_v fell without divider pulse");
  property p_pulse_one;
    div_pulse_o |=> !div_pulse_o [*8];
  endproperty
  a_pulse_one: assert property (p_pulse_one)
    else $error("divider pulse too long");
  property p_lo_gate;
    lo_output_disable_bit_o && $past(lo_output_disable_bit_o) |-> !lo_out_o;
  endproperty
  a_lo_gate: assert property (p_lo_gate)
    else $error("output active while disabled");
  property p_ack_cause;
    wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o;
  endproperty
  a_ack_cause: assert property (p_ack_cause)
    else $error("no ack one cycle after request");
  property p_ack_one;
    wb_ack_o |=> !wb_ack_o;
  endproperty
  a_ack_one: assert property (p_ack_one)
    else $error("ack longer than one cycle");
  property p_ack_req;
    wb_ack_o |-> $past(wb_cyc_i) && $past(wb_stb_i);
  endproperty
  a_ack_req: assert property (p_ack_req)
    else $error("ack without request");
  property p_wr_zero;
    wb_ack_o && $past(wb_we_i) |-> wb_dat_o == 32'h0;
  endproperty
  a_wr_zero: assert property (p_wr_zero)
    else $error("write returned data");
  c_ack: cover property (wb_ack_o && $past(wb_we_i));
  c_mod51: cover property (!modulus_high_o);
  c_ref_led: cover property (!phase_r_o);
endmodule
bind dmd_divider dmd_divider_chk dmd_divider_chk_inst (
  .clk_i(clk_i), .rst_i(rst_i), .ref_i(ref_i), .wb_cyc_i(wb_cyc_i),
  .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
  .modulus_high_o(modulus_high_o), .div_pulse_o(div_pulse_o), .phase_r_o(phase_r_o),
  .phase_v_o(phase_v_o), .lo_out_o(lo_out_o),
  .lo_output_disable_bit_o(lo_output_disable_bit_o)
);

// >>> sim/tb_dual_modulus_pll_divider.sv
`timescale 1ns/100ps
`define CHK(nm, e, g) begin check_count++; if ((g) !== (e)) begin err_count++; \
  $display("BAD %s exp %h got %h", nm, e, g); end end
module tb_dual_modulus_pll_divider;
  logic clk_i, rst_i, vco, ref_p, key, cyc, stb, we, ack, mod_hi, dpulse;
  logic ph_r, ph_v, lo, dis, st, ser_clk, ser_dat;
  logic [3:0] sstb, sel;
  logic [7:0] adr;
  logic [31:0] dat, rdat, q;
  int err_count, check_count;
  dmd_divider dmd_divider_inst (
    .clk_i(clk_i), .rst_i(rst_i), .vco_i(vco), .ref_i(ref_p),
    .transmit_keying_input_i(key), .module_control_bus_clk_i(ser_clk),
    .module_control_bus_data_i(ser_dat), .module_control_bus_strobe_i(sstb),
    .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
    .wb_dat_i(dat), .wb_dat_o(rdat), .wb_ack_o(ack), .modulus_high_o(mod_hi),
    .div_pulse_o(dpulse), .phase_r_o(ph_r), .phase_v_o(ph_v), .lo_out_o(lo),
    .lo_output_disable_bit_o(dis), .selftest_disable_bit_o(st));
  dmd_ctrl_model dmd_ctrl_model_inst (.clk_i(clk_i), .ser_clk_o(ser_clk),
    .ser_data_o(ser_dat), .strobe_o(sstb));
  initial begin
    clk_i = 1'b0;
    forever #4 clk_i = ~clk_i;
  end
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    dat <= d;
    @(posedge clk_i);
    while (ack !== 1'b1 && n < 50) begin
      @(posedge clk_i);
      n++;
    end
    if (n >= 50) err_count++;
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge clk_i);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e, input string nm);
    wb(1'b0, a, 32'h0);
    `CHK(nm, e, q)
  endtask
  // Park then restart: loads the preload of the current selection
  task automatic park();
    wb(1'b1, dmd_pkg::ADR_CTRL, 32'h0);
    wb(1'b1, dmd_pkg::ADR_CTRL, 32'h1);
  endtask
  task automatic vedges(input int n);
    repeat (n) begin
      repeat (4) @(posedge clk_i);
      vco <= 1'b1;
      repeat (4) @(posedge clk_i);
      vco <= 1'b0;
    end
    repeat (8) @(posedge clk_i);
  endtask
  task automatic complete_run();
    $display("checks %0d errors %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge clk_i);
    err_count++;
    complete_run();
  end
  initial begin
    {rst_i, vco, ref_p, key, cyc, stb, we, sel, adr, dat} = {1'b1, 6'h0, 4'h1, 40'h0};
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    repeat (3) @(posedge clk_i);
    `CHK("mod_hi", 1'b1, mod_hi)
    `CHK("phase", 2'b11, {ph_r, ph_v})
    rd(dmd_pkg::ADR_CTRL, 32'h1, "ctrl");
    rd(dmd_pkg::ADR_COUNT, 32'h0000038e, "count");
    rd(8'h1c, 32'h0, "unmapped");
    sel <= 4'h0;
    wb(1'b1, dmd_pkg::ADR_CTRL, 32'h0);
    sel <= 4'h1;
    rd(dmd_pkg::ADR_CTRL, 32'h1, "ctrl_sel");
    wb(1'b1, dmd_pkg::ADR_CAR_LOW, 32'hff);
    rd(dmd_pkg::ADR_CAR_LOW, 32'h0, "car_low");
    dmd_ctrl_model_inst.send(dmd_pkg::STB_CAR_LOW, 8'hcc);
    dmd_ctrl_model_inst.send(dmd_pkg::STB_CAR_MAIN, 8'h0e);
    dmd_ctrl_model_inst.send(dmd_pkg::STB_BEAT_LOW, 8'h23);
    dmd_ctrl_model_inst.send(dmd_pkg::STB_BEAT_MAIN, 8'h0d);
    rd(dmd_pkg::ADR_CAR_LOW, 32'hcc, "car_low");
    rd(dmd_pkg::ADR_BEAT_MAIN, 32'h0d, "beat_main");
    park();
    rd(dmd_pkg::ADR_COUNT, 32'h000c038e, "count");
    `CHK("mod_hi", 1'b0, mod_hi)
    `CHK("dis", 2'b11, {dis, st})
    vedges(51);
    rd(dmd_pkg::ADR_COUNT, 32'h000b038d, "count");
    vedges(11 * 51);
    rd(dmd_pkg::ADR_COUNT, 32'h00000382, "count");
    `CHK("mod_hi", 1'b1, mod_hi)
    vedges(50);
    rd(dmd_pkg::ADR_COUNT, 32'h00000381, "count");
    `CHK("lo_out", 1'b0, lo)
    key <= 1'b1;
    repeat (8) @(posedge clk_i);
    rd(dmd_pkg::ADR_COUNT, 32'h00000381, "count");
    wb(1'b0, dmd_pkg::ADR_STATUS, 32'h0);
    `CHK("beat_sel", 1'b0, q[0])
    park();
    rd(dmd_pkg::ADR_COUNT, 32'h0023038d, "count");
    wb(1'b0, dmd_pkg::ADR_STATUS, 32'h0);
    `CHK("beat_sel", 1'b1, q[0])
    `CHK("dis", 2'b00, {dis, st})
    `CHK("lo_out", 1'b1, lo)
    vedges(38);
    `CHK("lo_out", 1'b0, lo)
    ref_p <= 1'b1;
    repeat (40) @(posedge clk_i);
    ref_p <= 1'b0;
    repeat (4) @(posedge clk_i);
    `CHK("phase", 2'b01, {ph_r, ph_v})
    complete_run();
  end
endmodule
